/* File: logic/ucc_consts.svh */
`ifndef UCC_CONSTS_SVH
`define UCC_CONSTS_SVH
// Contract
// - tx A field E/F: pin a3 16X/1X
// - rx B field E/F: pin a6 16X/1X
// - tx B field E/F: pin a5 16X/1X
// - short received characters read zero-padded
// - short transmit characters carry zero upper bits
// - one write acts on both command nibbles
// - enable plus disable together means disable
// - disabled transmitter refuses queue writes
// - code 0 nop, 1/B set pointer 1/0
// - code 2 resets receiver, discards queue
// - code 3 resets transmitter, discards queue
// - code 4 clears break/parity/framing/overrun flags
// - code 5 clears break-change flag
// - code 6 starts break after queued characters
// - code 7 ends break, line marks
// - codes 8/9 drive request-to-send low/high
// - codes A/C timeout mode on/off
// - code D accumulates errors on queue load
// - power down codes only in channel A
// - change flags set on edge, read clears
// - low input-change bits show live pins
// - rx A field D timer, E/F pin a4
// - channel B break-change cleared by its command
// - change interrupt only when enable bit on

// byte offsets on the register bus
`define UCC_OFF_CLKSRC_A 8'h00
`define UCC_OFF_CLKSRC_B 8'h04
`define UCC_OFF_CMD_A    8'h08
`define UCC_OFF_CMD_B    8'h0C
`define UCC_OFF_RXD_A    8'h10
`define UCC_OFF_TXD_A    8'h14
`define UCC_OFF_RXD_B    8'h18
`define UCC_OFF_TXD_B    8'h1C
`define UCC_OFF_INCHG    8'h20
`define UCC_OFF_AUX      8'h24
`define UCC_OFF_STAT     8'h28
`define UCC_OFF_CLEN     8'h2C

// enable nibble bit positions
`define UCC_BIT_RX_EN  0
`define UCC_BIT_RX_DIS 1
`define UCC_BIT_TX_EN  2
`define UCC_BIT_TX_DIS 3

// clock field codes with special meaning
`define UCC_CLK_TIMER 4'hD
`define UCC_CLK_PIN16 4'hE
`define UCC_CLK_PIN1  4'hF

// reset values
`define UCC_CLKSRC_RST 8'h00
`define UCC_AUX_RST    8'h00
`define UCC_CLEN_RST   4'hF
`endif

/* File: logic/ucc_pkg.sv */
package ucc_pkg;
  // channel command codes, upper nibble of a command write
  typedef enum logic [3:0] {
    UCC_CMD_NOP = 4'h0, UCC_CMD_PTR1 = 4'h1, UCC_CMD_RX_RESET = 4'h2,
    UCC_CMD_TX_RESET = 4'h3, UCC_CMD_ERR_RESET = 4'h4, UCC_CMD_BRKCHG_RESET = 4'h5,
    UCC_CMD_BRK_START = 4'h6, UCC_CMD_BRK_STOP = 4'h7, UCC_CMD_RTS_ON = 4'h8,
    UCC_CMD_RTS_OFF = 4'h9, UCC_CMD_TMO_ON = 4'hA, UCC_CMD_PTR0 = 4'hB,
    UCC_CMD_TMO_OFF = 4'hC, UCC_CMD_BLK_ACC = 4'hD, UCC_CMD_PD_ON = 4'hE,
    UCC_CMD_PD_OFF = 4'hF
  } ucc_cmd_t;
  // bus slave states, one-hot
  typedef enum logic [1:0] {UCC_ST_IDLE = 2'b01, UCC_ST_ACC = 2'b10} ucc_st_t;
  // clock source kinds
  typedef enum logic [1:0] {UCC_SRC_BRG = 2'h0, UCC_SRC_TMR = 2'h1,
                            UCC_SRC_PIN16 = 2'h2, UCC_SRC_PIN1 = 2'h3} ucc_src_t;
  typedef struct packed {ucc_src_t src; logic x1;} ucc_clksel_t;
  // character handed over by the receiver; err = break, framing, parity, overrun
  typedef struct packed {logic valid; logic [7:0] data; logic [3:0] err;} ucc_rxchar_t;
  // per-channel state
  typedef struct packed {
    logic rx_en; logic tx_en; logic mr_ptr; logic request_to_send_n;
    logic brk; logic tmo; logic blk; logic pdown; logic brk_chg;
    logic [3:0] err; logic rx_full; logic [3:0] rx_err; logic [7:0] rx_data;
    logic tx_full; logic [7:0] tx_data;
    logic rx_rst; logic tx_rst; logic ct_restart; logic ct_stop;
  } ucc_chan_t;
  // keep only the bits of a 5..8 bit character
  function automatic logic [7:0] ucc_mask(logic [7:0] d, logic [1:0] clen);
    return d & (8'hFF >> (2'h3 - clen));
  endfunction
endpackage

/* File: logic/ucc_clk_sel.sv */
`timescale 1ns/1ps
`include "ucc_consts.svh"
module ucc_clk_sel (
  input  wire logic [3:0]          code,
  output ucc_pkg::ucc_clksel_t     sel
);
  import ucc_pkg::*;
  // decode one four-bit clock field; the rate-set bit never matters here
  always_comb begin
    sel = '{src: UCC_SRC_BRG, x1: 1'b0};        // table rates, always 16X
    if (code == `UCC_CLK_TIMER) begin
      sel.src = UCC_SRC_TMR;
    end else if (code == `UCC_CLK_PIN16) begin
      sel.src = UCC_SRC_PIN16;
    end else if (code == `UCC_CLK_PIN1) begin
      sel.src = UCC_SRC_PIN1;
      sel.x1  = 1'b1;                            // only this code gives 1X
    end
  end
endmodule // ucc_clk_sel

/* File: logic/ucc_chan.sv */
`timescale 1ns/1ps
`include "ucc_consts.svh"
module ucc_chan #(
  parameter bit IS_A = 1'b1                      // channel A also owns the global codes
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               cmd_we,        // command write, own address only
  input  wire logic [7:0]         cmd,
  input  wire logic               rx_rd,         // host read of the receive port
  input  wire logic               tx_wr,         // host write of the transmit port
  input  wire logic [7:0]         tx_din,
  input  wire logic               tx_take,       // transmitter took the held character
  input  wire logic [1:0]         clen,          // 0..3 = 5..8 bits
  input  ucc_pkg::ucc_rxchar_t    rx_in,
  input  wire logic               brk_evt,       // break began or ended
  output ucc_pkg::ucc_chan_t      st
);
  import ucc_pkg::*;
  ucc_chan_t st_ff;                              // all channel state
  ucc_chan_t nxt_st;                             // its next value

  // commands first, then data events, so an event in the clear cycle wins
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rx_rst = 1'b0;
    nxt_st.tx_rst = 1'b0;
    nxt_st.ct_restart = 1'b0;
    nxt_st.ct_stop = 1'b0;
    if (cmd_we) begin
      if (cmd[`UCC_BIT_RX_EN]) nxt_st.rx_en = 1'b1;
      if (cmd[`UCC_BIT_RX_DIS]) nxt_st.rx_en = 1'b0;
      if (cmd[`UCC_BIT_TX_EN]) nxt_st.tx_en = 1'b1;
      if (cmd[`UCC_BIT_TX_DIS]) nxt_st.tx_en = 1'b0;
      case (ucc_cmd_t'(cmd[7:4]))
        UCC_CMD_PTR1: nxt_st.mr_ptr = 1'b1;
        UCC_CMD_PTR0: nxt_st.mr_ptr = 1'b0;
        UCC_CMD_RX_RESET: begin
          nxt_st.rx_en = 1'b0;
          nxt_st.rx_full = 1'b0;
          nxt_st.err = 4'h0;
          nxt_st.rx_rst = 1'b1;
        end
        UCC_CMD_TX_RESET: begin
          nxt_st.tx_en = 1'b0;
          nxt_st.tx_full = 1'b0;
          nxt_st.brk = 1'b0;
          nxt_st.tx_rst = 1'b1;
        end
        UCC_CMD_ERR_RESET: nxt_st.err = 4'h0;
        UCC_CMD_BRKCHG_RESET: nxt_st.brk_chg = 1'b0;
        // break waits in the transmitter until it is idle
        UCC_CMD_BRK_START: nxt_st.brk = nxt_st.tx_en;
        UCC_CMD_BRK_STOP: nxt_st.brk = 1'b0;
        UCC_CMD_RTS_ON: nxt_st.request_to_send_n = 1'b0;
        UCC_CMD_RTS_OFF: nxt_st.request_to_send_n = 1'b1;
        UCC_CMD_TMO_ON: begin
          nxt_st.tmo = 1'b1;
          nxt_st.ct_stop = 1'b1;
        end
        UCC_CMD_TMO_OFF: nxt_st.tmo = 1'b0;
        UCC_CMD_BLK_ACC: nxt_st.blk = 1'b1;
        UCC_CMD_PD_ON: if (IS_A) nxt_st.pdown = 1'b1;
        UCC_CMD_PD_OFF: if (IS_A) nxt_st.pdown = 1'b0;
        default: ;                               // no command
      endcase
    end
    // transmit holding byte
    if (tx_take) nxt_st.tx_full = 1'b0;
    if (tx_wr && nxt_st.tx_en && !st_ff.tx_full) begin
      nxt_st.tx_full = 1'b1;
      nxt_st.tx_data = ucc_mask(tx_din, clen);
    end
    // host read: in character mode the flags follow the character read
    if (rx_rd && st_ff.rx_full) begin
      nxt_st.rx_full = 1'b0;
      if (!st_ff.blk) nxt_st.err[3:1] = nxt_st.err[3:1] | st_ff.rx_err[3:1];
    end
    // receiver load; a full holding byte that is not read now overruns
    if (rx_in.valid && nxt_st.rx_en) begin
      if (st_ff.rx_full && !rx_rd) begin
        nxt_st.err[0] = 1'b1;
      end else begin
        nxt_st.rx_full = 1'b1;
        nxt_st.rx_data = ucc_mask(rx_in.data, clen);
        nxt_st.rx_err = rx_in.err;
        nxt_st.ct_restart = st_ff.tmo;
        if (st_ff.blk) nxt_st.err[3:1] = nxt_st.err[3:1] | rx_in.err[3:1];
      end
    end
    if (brk_evt) nxt_st.brk_chg = 1'b1;          // set wins over clear
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.request_to_send_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign st = st_ff;

  property p_rxrst;
    @(posedge pclk) disable iff (!presetn)
      cmd_we && cmd[7:4] == 4'h2 |=> !st_ff.rx_full && !st_ff.rx_en && st_ff.rx_rst;
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("receiver reset missed");
  property p_txrst;
    @(posedge pclk) disable iff (!presetn)
      cmd_we && cmd[7:4] == 4'h3 |=> !st_ff.tx_full && !st_ff.tx_en && st_ff.tx_rst;
  endproperty
  a_txrst: assert property (p_txrst) else $error("transmitter reset missed");
  property p_tmo;
    @(posedge pclk) disable iff (!presetn)
      cmd_we && cmd[7:4] == 4'hA |=> st_ff.tmo && st_ff.ct_stop;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout mode not started");
  property p_errclr;
    @(posedge pclk) disable iff (!presetn)
      cmd_we && cmd[7:4] == 4'h4 && !rx_in.valid && !rx_rd |=> st_ff.err == 4'h0;
  endproperty
  a_errclr: assert property (p_errclr) else $error("error flags not cleared");
  property p_pdown;
    @(posedge pclk) disable iff (!presetn)
      cmd_we && cmd[7:4] == 4'hE |=> st_ff.pdown == IS_A;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down decode wrong");
endmodule // ucc_chan

/* File: logic/ucc_channel_ctrl.sv */
`timescale 1ns/1ps
`include "ucc_consts.svh"
module ucc_channel_ctrl (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  ucc_pkg::ucc_rxchar_t       rx_in_a,
  input  ucc_pkg::ucc_rxchar_t       rx_in_b,
  input  wire logic                  brk_evt_a,
  input  wire logic                  brk_evt_b,
  input  wire logic                  tx_take_a,
  input  wire logic                  tx_take_b,
  input  wire logic [3:0]            aux_in,
  output ucc_pkg::ucc_chan_t         chan_a,
  output ucc_pkg::ucc_chan_t         chan_b,
  output ucc_pkg::ucc_clksel_t [3:0] clk_sel,
  output logic                       rate_set,
  output logic                       in_chg_int
);
  import ucc_pkg::*;

  // whole top-level state in one record
  typedef struct packed {
    ucc_st_t fsm;                                // bus slave phase
    logic pready;
    logic pslverr;
    logic [31:0] rdata;                          // read data captured at setup
    logic [7:0] clksrc_a;
    logic [7:0] clksrc_b;
    logic [7:0] aux;                             // rate set and change enables
    logic [3:0] clen;                            // [1:0] channel A, [3:2] channel B
    logic [3:0] pins;                            // last sampled input levels
    logic [3:0] chg;                             // sticky change flags
    logic [3:0] cap;                             // flags shown by the pending read
    logic in_chg;                                // input change interrupt status
    ucc_clksel_t [3:0] ck;                       // decoded clock sources
  } ucc_top_t;

  ucc_top_t s_ff;                                // registered state
  ucc_top_t nxt_s;                               // next state
  ucc_clksel_t [3:0] ck_w;                       // decoder outputs
  logic [15:0] fields;                           // four clock fields side by side
  logic [3:0] edges;                             // pins that moved this cycle
  logic done;                                    // access completes at this edge
  logic wr;                                      // completing write
  logic rd;                                      // completing read
  logic [31:0] rd_val;                           // read mux
  logic hit;                                     // address is mapped
  logic cmd_we_a;                                // command strobes per channel
  logic cmd_we_b;
  logic rx_rd_a;                                 // receive port read strobes
  logic rx_rd_b;
  logic tx_wr_a;                                 // transmit port write strobes
  logic tx_wr_b;

  // pack a channel's state for the status word
  function automatic logic [15:0] stat16(ucc_chan_t c);
    return {1'b0, c.request_to_send_n, c.tx_full, c.rx_full, c.err,
            c.pdown, c.brk_chg, c.tmo, c.blk, c.brk, c.mr_ptr, c.tx_en, c.rx_en};
  endfunction

  // field order: tx A, rx A, tx B, rx B
  assign fields = {s_ff.clksrc_b, s_ff.clksrc_a};

  // one decoder per clock field
  for (genvar i = 0; i < 4; i++) begin : g_ck
    ucc_clk_sel u_sel (
      .code (fields[4*i +: 4]),
      .sel  (ck_w[i])
    );
  end

  // bus strobes; the command and port strobes are each tied to their own register address
  assign done     = psel && penable && s_ff.pready;
  assign wr       = done && pwrite;
  assign rd       = done && !pwrite;
  assign cmd_we_a = wr && paddr == `UCC_OFF_CMD_A;
  assign cmd_we_b = wr && paddr == `UCC_OFF_CMD_B;
  assign tx_wr_a  = wr && paddr == `UCC_OFF_TXD_A;
  assign tx_wr_b  = wr && paddr == `UCC_OFF_TXD_B;
  assign rx_rd_a  = rd && paddr == `UCC_OFF_RXD_A;
  assign rx_rd_b  = rd && paddr == `UCC_OFF_RXD_B;
  assign edges    = aux_in ^ s_ff.pins;

  // address decode and read mux; write-only ports read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == `UCC_OFF_CLKSRC_A) begin
      rd_val[7:0] = s_ff.clksrc_a;
    end else if (paddr == `UCC_OFF_CLKSRC_B) begin
      rd_val[7:0] = s_ff.clksrc_b;
    end else if (paddr == `UCC_OFF_CMD_A || paddr == `UCC_OFF_CMD_B) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == `UCC_OFF_TXD_A || paddr == `UCC_OFF_TXD_B) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == `UCC_OFF_RXD_A) begin
      rd_val[7:0] = ucc_mask(chan_a.rx_data, s_ff.clen[1:0]);
    end else if (paddr == `UCC_OFF_RXD_B) begin
      rd_val[7:0] = ucc_mask(chan_b.rx_data, s_ff.clen[3:2]);
    end else if (paddr == `UCC_OFF_INCHG) begin
      rd_val[7:0] = {s_ff.chg, aux_in};
    end else if (paddr == `UCC_OFF_AUX) begin
      rd_val[7:0] = s_ff.aux;
    end else if (paddr == `UCC_OFF_STAT) begin
      rd_val = {stat16(chan_b), stat16(chan_a)};
      rd_val[15] = s_ff.in_chg;
    end else if (paddr == `UCC_OFF_CLEN) begin
      rd_val[3:0] = s_ff.clen;
    end else begin
      hit = 1'b0;                                // unmapped: zero data, error
    end
  end

  // next state: bus phases, register writes, change flags
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ck = ck_w;
    nxt_s.pins = aux_in;
    case (s_ff.fsm)
      UCC_ST_IDLE: begin
        nxt_s.pready = 1'b0;
        if (psel && !penable) begin              // setup cycle seen
          nxt_s.fsm = UCC_ST_ACC;
          nxt_s.pready = 1'b1;
          nxt_s.rdata = pwrite ? 32'h0000_0000 : rd_val;
          nxt_s.pslverr = !hit;
          nxt_s.cap = (!pwrite && paddr == `UCC_OFF_INCHG) ? s_ff.chg : 4'h0;
        end
      end
      UCC_ST_ACC: begin
        if (done || !psel) begin                 // finished or abandoned
          nxt_s.fsm = UCC_ST_IDLE;
          nxt_s.pready = 1'b0;
          nxt_s.pslverr = 1'b0;
        end
      end
      default: begin
        nxt_s.fsm = UCC_ST_IDLE;
        nxt_s.pready = 1'b0;
      end
    endcase
    if (wr) begin
      if (paddr == `UCC_OFF_CLKSRC_A) begin
        nxt_s.clksrc_a = pwdata[7:0];
      end else if (paddr == `UCC_OFF_CLKSRC_B) begin
        nxt_s.clksrc_b = pwdata[7:0];
      end else if (paddr == `UCC_OFF_AUX) begin
        nxt_s.aux = pwdata[7:0];
      end else if (paddr == `UCC_OFF_CLEN) begin
        nxt_s.clen = pwdata[3:0];
      end
    end
    // a read clears only the flags it showed, so a change during it survives
    if (rd && paddr == `UCC_OFF_INCHG) begin
      nxt_s.chg = s_ff.chg & ~s_ff.cap;
      nxt_s.in_chg = 1'b0;
    end
    nxt_s.chg = nxt_s.chg | edges;
    if (|(edges & s_ff.aux[3:0])) nxt_s.in_chg = 1'b1;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.fsm <= UCC_ST_IDLE;
      s_ff.clksrc_a <= `UCC_CLKSRC_RST;
      s_ff.clksrc_b <= `UCC_CLKSRC_RST;
      s_ff.aux <= `UCC_AUX_RST;
      s_ff.clen <= `UCC_CLEN_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // channel A also decodes the global power codes
  ucc_chan #(.IS_A(1'b1)) u_chan_a (
    .pclk    (pclk),
    .presetn (presetn),
    .cmd_we  (cmd_we_a),
    .cmd     (pwdata[7:0]),
    .rx_rd   (rx_rd_a),
    .tx_wr   (tx_wr_a),
    .tx_din  (pwdata[7:0]),
    .tx_take (tx_take_a),
    .clen    (s_ff.clen[1:0]),
    .rx_in   (rx_in_a),
    .brk_evt (brk_evt_a),
    .st      (chan_a)
  );

  // channel B ignores them
  ucc_chan #(.IS_A(1'b0)) u_chan_b (
    .pclk    (pclk),
    .presetn (presetn),
    .cmd_we  (cmd_we_b),
    .cmd     (pwdata[7:0]),
    .rx_rd   (rx_rd_b),
    .tx_wr   (tx_wr_b),
    .tx_din  (pwdata[7:0]),
    .tx_take (tx_take_b),
    .clen    (s_ff.clen[3:2]),
    .rx_in   (rx_in_b),
    .brk_evt (brk_evt_b),
    .st      (chan_b)
  );

  // outputs straight from flops
  assign prdata     = s_ff.rdata;
  assign pready     = s_ff.pready;
  assign pslverr    = s_ff.pslverr;
  assign clk_sel    = s_ff.ck;
  assign rate_set   = s_ff.aux[7];
  assign in_chg_int = s_ff.in_chg;

  property p_both_dis;
    @(posedge pclk) disable iff (!presetn)
      cmd_we_a && pwdata[1:0] == 2'b11 && pwdata[7:4] != 4'h2 |=> !chan_a.rx_en;
  endproperty
  a_both_dis: assert property (p_both_dis) else $error("enable beat disable");
  property p_en_nib;
    @(posedge pclk) disable iff (!presetn)
      cmd_we_b && pwdata[3:2] == 2'b01 && pwdata[7:4] != 4'h3 |=> chan_b.tx_en;
  endproperty
  a_en_nib: assert property (p_en_nib) else $error("tx enable ignored");
  property p_tx_refuse;
    @(posedge pclk) disable iff (!presetn)
      tx_wr_a && !chan_a.tx_en && !cmd_we_a && !tx_take_a |=> chan_a.tx_full == $past(chan_a.tx_full);
  endproperty
  a_tx_refuse: assert property (p_tx_refuse) else $error("disabled tx accepted");
  property p_rts;
    @(posedge pclk) disable iff (!presetn)
      cmd_we_a && pwdata[7:4] == 4'h8 |=> !chan_a.request_to_send_n ##1 chan_a.request_to_send_n == $past(chan_a.request_to_send_n) || $past(cmd_we_a);
  endproperty
  a_rts: assert property (p_rts) else $error("request to send not low");
  property p_chg_clr;
    @(posedge pclk) disable iff (!presetn)
      rd && paddr == `UCC_OFF_INCHG && (edges & s_ff.aux[3:0]) == 4'h0 |=> !in_chg_int;
  endproperty
  a_chg_clr: assert property (p_chg_clr) else $error("change status not cleared");
  property p_live;
    @(posedge pclk) disable iff (!presetn)
      s_ff.fsm == UCC_ST_IDLE && psel && !penable && !pwrite && paddr == `UCC_OFF_INCHG
        |=> prdata[3:0] == $past(aux_in);
  endproperty
  a_live: assert property (p_live) else $error("live levels wrong");
  property p_masked;
    @(posedge pclk) disable iff (!presetn)
      s_ff.aux[3:0] == 4'h0 && !in_chg_int && !(rd && paddr == `UCC_OFF_INCHG) |=> !in_chg_int;
  endproperty
  a_masked: assert property (p_masked) else $error("masked change raised status");
  property p_timer;
    @(posedge pclk) disable iff (!presetn)
      wr && paddr == `UCC_OFF_CLKSRC_A && pwdata[7:4] == 4'hD |=> ##1 clk_sel[1].src == UCC_SRC_TMR;
  endproperty
  a_timer: assert property (p_timer) else $error("timer source not chosen");
  property p_pin1x;
    @(posedge pclk) disable iff (!presetn)
      wr && paddr == `UCC_OFF_CLKSRC_B && pwdata[7:4] == 4'hF |=> ##1 clk_sel[3].x1 && clk_sel[3].src == UCC_SRC_PIN1;
  endproperty
  a_pin1x: assert property (p_pin1x) else $error("1X pin clock not chosen");
endmodule // ucc_channel_ctrl

/* File: tb/ucc_host.sv */
`timescale 1ns/1ps
// apb master standing in for the host cpu on the register bus
module ucc_host (
  input  wire logic        pclk,
  output logic [7:0]       paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // bus idle from time zero
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  // one transfer; the leading edge keeps back-to-back calls from reassigning psel in one step
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold everything until pready is seen; a dead slave is left to the bench watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // ucc_host

/* File: tb/uart_channel_command_clock_select_bench.sv */
`timescale 1ns/1ps
`include "ucc_consts.svh"
module uart_channel_command_clock_select_bench;
  import ucc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [3:0] sel; logic [11:0] exp;} ucc_row_t;
  logic pclk, presetn, pwrite, psel, penable, pready, pslverr, brk_a, brk_b, rate_set, in_chg_int;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  logic [3:0] aux_in;
  ucc_rxchar_t rx_a;
  ucc_chan_t chan_a, chan_b;
  ucc_clksel_t [3:0] clk_sel;
  int error_cnt = 0;
  int n_checks = 0;
  // ordinary cases: write, then one field, or all four clock select fields, that must follow
  ucc_row_t rows [21] = '{
    '{`UCC_OFF_CMD_A, 8'h05, 0, 1}, '{`UCC_OFF_CMD_A, 8'h0F, 1, 0},
    '{`UCC_OFF_CMD_A, 8'h10, 2, 1}, '{`UCC_OFF_CMD_A, 8'h00, 2, 1}, '{`UCC_OFF_CMD_A, 8'hB0, 2, 0},
    '{`UCC_OFF_CMD_A, 8'h80, 3, 0}, '{`UCC_OFF_CMD_A, 8'h90, 3, 1}, '{`UCC_OFF_CMD_B, 8'h80, 3, 1},
    '{`UCC_OFF_CMD_A, 8'h60, 4, 0}, '{`UCC_OFF_CMD_A, 8'h64, 4, 1}, '{`UCC_OFF_CMD_A, 8'h70, 4, 0},
    '{`UCC_OFF_CMD_A, 8'hA0, 5, 1}, '{`UCC_OFF_CMD_A, 8'hC0, 5, 0}, '{`UCC_OFF_CMD_A, 8'hD0, 6, 1},
    '{`UCC_OFF_CMD_B, 8'hE0, 8, 0}, '{`UCC_OFF_CMD_A, 8'hE0, 7, 1}, '{`UCC_OFF_CMD_A, 8'hF0, 7, 0},
    '{`UCC_OFF_CLKSRC_A, 8'hFE, 9, 12'h03C}, '{`UCC_OFF_CLKSRC_B, 8'hFE, 9, 12'hF3C},
    '{`UCC_OFF_CLKSRC_B, 8'hEF, 9, 12'h9FC}, '{`UCC_OFF_CLKSRC_A, 8'hD5, 9, 12'h9D0}};
  ucc_channel_ctrl ucc_channel_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_in_a(rx_a), .rx_in_b('0), .brk_evt_a(brk_a), .brk_evt_b(brk_b), .tx_take_a(1'b0), .tx_take_b(1'b0),
    .aux_in(aux_in), .chan_a(chan_a), .chan_b(chan_b), .clk_sel(clk_sel), .rate_set(rate_set),
    .in_chg_int(in_chg_int));
  ucc_host ucc_host_inst (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // 10 mhz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // picks the field a row looks at
  function automatic logic [11:0] pick(input logic [3:0] s);
    case (s)
      0: return chan_a.rx_en;
      1: return chan_a.tx_en;
      2: return chan_a.mr_ptr;
      3: return chan_a.request_to_send_n;
      4: return chan_a.brk;
      5: return chan_a.tmo;
      6: return chan_a.blk;
      7: return chan_a.pdown;
      8: return chan_b.pdown;
      default: return clk_sel;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // write, then leave the spacing that command writes need and clock select settles in
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ucc_host_inst.xfer(a, 1'b1, {24'h0, d}, q, e);
    repeat (3) @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a);
    ucc_host_inst.xfer(a, 1'b0, 32'h0, q, e);
  endtask
  // one received character, a single-cycle pulse
  task automatic rx_char(input logic [7:0] d, input logic [3:0] er);
    rx_a <= '{valid: 1'b1, data: d, err: er};
    @(posedge pclk);
    rx_a <= '0;
    @(posedge pclk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    presetn = 1'b0;
    aux_in = 4'h0;
    rx_a = '0;
    brk_a = 1'b0;
    brk_b = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk($sformatf("row %0d", i), rows[i].exp, pick(rows[i].sel));
    end
    $display("test rows done");
    rd(`UCC_OFF_CLKSRC_A);
    chk("clock source read", 32'hD5, q);
    rd(8'h30);
    chk("unmapped error", 1, e);
    wr(`UCC_OFF_CLEN, 8'h0C); // channel a 5 bit characters
    wr(`UCC_OFF_CMD_A, 8'h08);
    wr(`UCC_OFF_TXD_A, 8'hFF);
    chk("tx refused", 0, chan_a.tx_full);
    wr(`UCC_OFF_CMD_A, 8'h04);
    wr(`UCC_OFF_TXD_A, 8'hFF);
    chk("tx data", 8'h1F, chan_a.tx_data);
    wr(`UCC_OFF_CMD_A, 8'h30);
    chk("tx reset", 0, {chan_a.tx_full, chan_a.tx_en});
    $display("test transmit done");
    wr(`UCC_OFF_CMD_A, 8'h01);
    rx_char(8'hFF, 4'hE);
    chk("err on load", 4'hE, chan_a.err);
    rd(`UCC_OFF_RXD_A);
    chk("rx data", 32'h1F, q);
    wr(`UCC_OFF_CMD_A, 8'h40);
    chk("err reset", 0, chan_a.err);
    rx_char(8'h01, 4'h0);
    wr(`UCC_OFF_CMD_A, 8'h20);
    chk("rx reset", 0, {chan_a.rx_full, chan_a.rx_en});
    $display("test receive done");
    brk_a <= 1'b1;
    brk_b <= 1'b1;
    @(posedge pclk);
    brk_a <= 1'b0;
    brk_b <= 1'b0;
    wr(`UCC_OFF_CMD_A, 8'h50);
    chk("break change a b", 2'b01, {chan_a.brk_chg, chan_b.brk_chg});
    wr(`UCC_OFF_CMD_B, 8'h54);
    chk("break change b", 2'b01, {chan_b.brk_chg, chan_b.tx_en});
    $display("test break change done");
    wr(`UCC_OFF_AUX, 8'h81);
    chk("rate set keeps pins", {1'b1, 12'h9D0}, {rate_set, clk_sel});
    aux_in <= 4'h3;
    repeat (3) @(posedge pclk);
    chk("change int", 1, in_chg_int);
    rd(`UCC_OFF_INCHG);
    chk("input change", 32'h33, q);
    aux_in <= 4'h1;
    repeat (3) @(posedge pclk);
    chk("change int masked", 0, in_chg_int);
    rd(`UCC_OFF_INCHG);
    chk("input change 2", 32'h21, q);
    $display("test input change done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset state", {1'b1, 12'h000, 1'b0}, {chan_a.request_to_send_n, clk_sel, chan_a.rx_en});
    presetn <= 1'b1;
    rd(`UCC_OFF_CLEN);
    chk("length after reset", 32'hF, q);
    $display("test reset done");
    end_sim();
  end
endmodule // uart_channel_command_clock_select_bench
